// file: verif/lpmc_checker.sv
// Port assertions for the low-power mode controller
`default_nettype none
module lpmc_checker (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	// Causes
	input wire logic wait_for_irq_instr,
	input wire logic send_event_instr,
	input wire logic stop_ack_all,
	input wire logic wake_unit_pin,
	input wire logic reset_pin_n,
	// Effects
	input wire logic event_out,
	input wire logic core_sleeping,
	input wire lpmc_pkg::lpmc_clk_t clk_en,
	input wire lpmc_pkg::lpmc_pwr_t pwr,
	input wire logic restart_req
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	chk_wfi_enter: assert property (wait_for_irq_instr && ce && !core_sleeping && !restart_req |=> core_sleeping)
		else $error("wfi did not sleep");
	chk_sleep_core: assert property (core_sleeping |-> !clk_en.core)
		else $error("core clock runs while asleep");
	chk_deep_gates: assert property (!clk_en.sys |-> !clk_en.pll && !clk_en.flash && !clk_en.core)
		else $error("system clock off but pll or flash on");
	chk_gate_order: assert property ($fell(clk_en.master) |-> $past(stop_ack_all) && !$past(clk_en.core))
		else $error("masters gated before acknowledge");
	chk_event_echo: assert property (send_event_instr && ce |=> event_out)
		else $error("send event not echoed");
	chk_leak_deaf: assert property ((!pwr.logic_on && !wake_unit_pin && reset_pin_n && ce)[*5] |=> !pwr.logic_on)
		else $error("woke from leakage without wake source");
	chk_leak_power: assert property (!pwr.logic_on |-> pwr.reg_lowpower && pwr.freq_limit && pwr.io_hold)
		else $error("leakage power settings wrong");
	chk_ram_osc: assert property ((!pwr.ram_on |-> !pwr.logic_on) and (!pwr.osc_1k_on |-> !pwr.ram_on))
		else $error("ram or oscillator off outside leakage");
	chk_restart_once: assert property (restart_req && ce |=> !restart_req && !core_sleeping)
		else $error("restart not a single cycle");
	cover property (restart_req);
	cover property ($fell(clk_en.master));
	cover property (core_sleeping && clk_en.sys);
endmodule
bind lpmc_ctrl lpmc_checker i_lpmc_checker (.clk_sys, .rst_n, .ce, .wait_for_irq_instr, .send_event_instr,
	.stop_ack_all, .wake_unit_pin, .reset_pin_n, .event_out, .core_sleeping, .clk_en, .pwr, .restart_req);
`default_nettype wire

// file: verif/lpmc_peer.sv
// Peripheral side model: stop acknowledges, prompt or slow
`default_nettype none
module lpmc_peer (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Speed select and gating view
	input wire logic slow,
	input wire lpmc_pkg::lpmc_clk_t clk_en,
	// Acknowledge
	output logic stop_ack_all
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] cnt_q;
	// Acknowledge only once the core clock is gated, withdraw it on wake
	always_ff @(posedge clk_sys) begin
		if (!rst_n || clk_en.core) begin
			cnt_q <= 3'h0;
			stop_ack_all <= 1'h0;
		end else begin
			cnt_q <= (cnt_q == 3'h7) ? cnt_q : cnt_q + 3'h1;
			stop_ack_all <= cnt_q >= (slow ? 3'h5 : 3'h0);
		end
	end
endmodule
`default_nettype wire

// file: verif/test_low_power_mode_controller.sv
// Self-checking bench for the low-power mode controller
`default_nettype none
module test_low_power_mode_controller;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, rst_n, ce, psel, penable, pwrite, pready, pslverr, err, irq_pend_enabled, ext_event_pin;
	logic event_out, stop_ack_all, wake_unit_pin, reset_pin_n, core_sleeping, restart_req, wake_unit_irq, slow, po;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, v;
	// Pulses: 0 wfi, 1 wfe, 2 sev, 3 handler return, 4 new pending
	logic [4:0] ins;
	lpmc_pkg::lpmc_clk_t clk_en;
	lpmc_pkg::lpmc_pwr_t pwr;
	int fail_count, checks_done, w;
	lpmc_ctrl i_lpmc_ctrl (.clk_sys, .rst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .wait_for_irq_instr(ins[0]), .wait_for_event_instr(ins[1]), .send_event_instr(ins[2]),
		.handler_return(ins[3]), .irq_new_pend(ins[4]), .irq_pend_enabled, .ext_event_pin, .event_out,
		.stop_ack_all, .wake_unit_pin, .reset_pin_n, .core_sleeping, .clk_en, .pwr, .restart_req, .wake_unit_irq);
	lpmc_peer i_lpmc_peer (.clk_sys, .rst_n, .slow, .clk_en, .stop_ack_all);
	initial begin
		clk_sys = 1'h0;
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'h1;
		do @(posedge clk_sys); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		// Let the write settle before the caller looks at outputs
		#1;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic pulse(input int b);
		@(posedge clk_sys);
		ins[b] <= 1'h1;
		@(posedge clk_sys);
		ins[b] <= 1'h0;
		#1;
	endtask
	task automatic do_reset;
		@(posedge clk_sys);
		rst_n <= 1'h0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'h1;
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#60000;
		fail_count++;
		end_of_test();
	end
	initial begin
		{psel, penable, pwrite, irq_pend_enabled, ext_event_pin, wake_unit_pin, slow, rst_n} = 8'h0;
		{ce, reset_pin_n, paddr, pwdata, ins} = {2'h3, 45'h0};
		fail_count = 0;
		checks_done = 0;
		v = $urandom(32'h5df2);
		do_reset();
		apb(1'h0, lpmc_pkg::ADDR_MODE_CTRL, 32'h0);
		check("mode reset", rd, 32'h30);
		apb(1'h0, 8'h10, 32'h0);
		check("unmapped", {rd[30:0], err}, 32'h1);
		for (int i = 0; i < 4; i++) begin
			v = $urandom();
			apb(1'h1, lpmc_pkg::ADDR_MODE_CTRL, v);
			apb(1'h0, lpmc_pkg::ADDR_MODE_CTRL, 32'h0);
			check("mode rw", rd, v & 32'h1137);
			apb(1'h1, lpmc_pkg::ADDR_SLEEP_CTRL, v);
			apb(1'h1, lpmc_pkg::ADDR_STATUS, v);
			apb(1'h0, lpmc_pkg::ADDR_SLEEP_CTRL, 32'h0);
			check("sleep rw", rd, v & 32'h16);
		end
		$display("test registers done");
		do_reset();
		@(posedge clk_sys);
		ce <= 1'h0;
		pulse(0);
		check("frozen", core_sleeping, 1'h0);
		ce <= 1'h1;
		pulse(0);
		check("wfi", {core_sleeping, clk_en.core, clk_en.sys, clk_en.flash}, 4'hB);
		@(posedge clk_sys);
		irq_pend_enabled <= 1'h1;
		cyc(2);
		check("irq wake", core_sleeping, 1'h0);
		irq_pend_enabled <= 1'h0;
		pulse(2);
		check("echo", event_out, 1'h1);
		apb(1'h0, lpmc_pkg::ADDR_STATUS, 32'h0);
		check("flag", rd[5:4], 2'h1);
		pulse(1);
		check("wfe flag", core_sleeping, 1'h0);
		pulse(1);
		check("wfe sleep", core_sleeping, 1'h1);
		ext_event_pin <= 1'h1;
		cyc(5);
		check("ext wake", core_sleeping, 1'h0);
		ext_event_pin <= 1'h0;
		pulse(2);
		pulse(1);
		pulse(1);
		pulse(4);
		cyc(2);
		check("masked pend", core_sleeping, 1'h1);
		apb(1'h1, lpmc_pkg::ADDR_SLEEP_CTRL, 32'h10);
		pulse(4);
		cyc(2);
		check("pend event", core_sleeping, 1'h0);
		apb(1'h1, lpmc_pkg::ADDR_SLEEP_CTRL, 32'h2);
		pulse(3);
		check("after handler", core_sleeping, 1'h1);
		$display("test sleep and events done");
		for (int k = 0; k < 2; k++) begin
			do_reset();
			slow <= k[0];
			apb(1'h1, lpmc_pkg::ADDR_MODE_CTRL, k ? 32'h1003 : 32'h0);
			check("run reg", {pwr.reg_lowpower, pwr.freq_limit}, k ? 2'h3 : 2'h0);
			pulse(0);
			check("light", {clk_en.core, clk_en.sys, clk_en.bus, clk_en.flash, pwr.reg_lowpower},
				{1'h0, 1'h1, k[0], 1'h1, k[0]});
			irq_pend_enabled <= 1'h1;
			cyc(2);
			irq_pend_enabled <= 1'h0;
			check("light wake", core_sleeping, 1'h0);
			apb(1'h1, lpmc_pkg::ADDR_SLEEP_CTRL, 32'h4);
			pulse(0);
			check("ack wait", {clk_en.core, clk_en.master}, 2'h1);
			cyc(12);
			check("stop", {clk_en, pwr.reg_lowpower}, {6'h0, k[0]});
		end
		$display("test stop done");
		for (int l = 3; l >= 0; l--) begin
			do_reset();
			po = 1'($urandom());
			slow <= 1'($urandom());
			apb(1'h1, lpmc_pkg::ADDR_MODE_CTRL, {23'h0, po, 2'h0, l[1:0], 4'h4});
			apb(1'h1, lpmc_pkg::ADDR_SLEEP_CTRL, 32'h4);
			pulse(0);
			cyc(12);
			check("leak", {pwr.logic_on, pwr.ram_on, pwr.io_hold, pwr.osc_1k_on, pwr.por_on},
				{1'h0, l > 1, 1'h1, l > 0, l > 0 || po});
			irq_pend_enabled <= 1'h1;
			cyc(6);
			check("deaf", {restart_req, pwr.logic_on}, 2'h0);
			irq_pend_enabled <= 1'h0;
			if (l == 0)
				reset_pin_n <= 1'h0;
			else
				wake_unit_pin <= 1'h1;
			w = 0;
			while (restart_req !== 1'h1 && w < 20) begin
				@(posedge clk_sys);
				w++;
			end
			check("restart", w < 20, 1'h1);
			reset_pin_n <= 1'h1;
			wake_unit_pin <= 1'h0;
			apb(1'h0, lpmc_pkg::ADDR_WAKE_FLAGS, 32'h0);
			check("flags", {rd[2:0], pwr.io_hold}, {1'h1, l == 0, l != 0, 1'h1});
			if (l != 0)
				check("wake irq", wake_unit_irq, 1'h1);
			apb(1'h1, lpmc_pkg::ADDR_WAKE_FLAGS, 32'h4);
			apb(1'h0, lpmc_pkg::ADDR_WAKE_FLAGS, 32'h0);
			check("iso clear", {rd[2], pwr.io_hold}, 2'h0);
			apb(1'h0, lpmc_pkg::ADDR_MODE_CTRL, 32'h0);
			check("restart regs", rd, 32'h30);
		end
		$display("test leakage done");
		end_of_test();
	end
endmodule
`default_nettype wire

// file: verilog/lpmc_ctrl.sv
// Low-power mode controller: sleep entry, mode clocking, power and wakeup
//
// Chosen here: the APB register port and the register offsets.
`default_nettype none
module lpmc_ctrl (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core instruction and interrupt status
	input wire logic wait_for_irq_instr,
	input wire logic wait_for_event_instr,
	input wire logic send_event_instr,
	input wire logic handler_return,
	input wire logic irq_pend_enabled,
	input wire logic irq_new_pend,
	// System side
	input wire logic ext_event_pin,
	output logic event_out,
	input wire logic stop_ack_all,
	input wire logic wake_unit_pin,
	input wire logic reset_pin_n,
	// Clock and power control
	output logic core_sleeping,
	output lpmc_pkg::lpmc_clk_t clk_en,
	output lpmc_pkg::lpmc_pwr_t pwr,
	output logic restart_req,
	output logic wake_unit_irq
);
	typedef struct packed {
		lpmc_pkg::lpmc_fsm_t fsm;
		logic sah;
		logic deep;
		logic eop;
		logic run_lp;
		lpmc_pkg::lpmc_stop_t stop_kind;
		logic [1:0] lvl;
		logic por_opt;
		logic bus_on;
		logic evt_flag;
		logic wfe_wait;
		logic iso;
		logic irq_pend;
		logic wk_unit;
		logic wk_rst;
		logic ev_out;
		logic ext_s1;
		logic ext_s2;
		logic wku_s1;
		logic wku_s2;
		logic rpin_s1;
		logic rpin_s2;
		logic [31:0] rdata;
	} state_t;

	state_t s_q;
	state_t s_d;

	function automatic logic addr_hit(input logic [7:0] a);
		addr_hit = (a == lpmc_pkg::ADDR_SLEEP_CTRL) || (a == lpmc_pkg::ADDR_MODE_CTRL) ||
			(a == lpmc_pkg::ADDR_STATUS) || (a == lpmc_pkg::ADDR_WAKE_FLAGS);
	endfunction

	function automatic logic in_state(input lpmc_pkg::lpmc_fsm_t f, input lpmc_pkg::lpmc_fsm_t t);
		in_state = (f == t);
	endfunction

	logic wr_en;
	logic sleep_go;
	logic event_in;
	logic asleep;
	logic wake;
	logic leak_wake;
	logic [31:0] rd_mux;

	always_comb begin
		s_d = s_q;
		rd_mux = '0;
		wr_en = psel && penable && pwrite;
		asleep = !in_state(s_q.fsm, lpmc_pkg::FSM_RUN) && !in_state(s_q.fsm, lpmc_pkg::FSM_RESTART);
		// Synchronisers: only the second stage is read by logic
		s_d.ext_s1 = ext_event_pin;
		s_d.ext_s2 = s_q.ext_s1;
		s_d.wku_s1 = wake_unit_pin;
		s_d.wku_s2 = s_q.wku_s1;
		s_d.rpin_s1 = reset_pin_n;
		s_d.rpin_s2 = s_q.rpin_s1;
		// External events, and pending interrupts when enabled to count as events
		event_in = s_q.ext_s2 || (s_q.eop && irq_new_pend);
		// Only enabled interrupts, or events for a wait-for-event sleep, end a sleep other than a leakage one
		wake = irq_pend_enabled || (s_q.wfe_wait && event_in);
		leak_wake = s_q.wku_s2 || !s_q.rpin_s2;
		sleep_go = wait_for_irq_instr ||
			(wait_for_event_instr && !s_q.evt_flag) ||
			(handler_return && s_q.sah);
		s_d.ev_out = send_event_instr;

		// Register reads are captured in the setup phase
		case (paddr)
			lpmc_pkg::ADDR_SLEEP_CTRL: begin
				rd_mux[lpmc_pkg::SC_SAH] = s_q.sah;
				rd_mux[lpmc_pkg::SC_DEEP] = s_q.deep;
				rd_mux[lpmc_pkg::SC_EOP] = s_q.eop;
			end
			lpmc_pkg::ADDR_MODE_CTRL: begin
				rd_mux[lpmc_pkg::MC_RUN_LP] = s_q.run_lp;
				rd_mux[lpmc_pkg::MC_STOP_LO +: 2] = s_q.stop_kind;
				rd_mux[lpmc_pkg::MC_LVL_LO +: 2] = s_q.lvl;
				rd_mux[lpmc_pkg::MC_POR] = s_q.por_opt;
				rd_mux[lpmc_pkg::MC_BUS_CLK] = s_q.bus_on;
			end
			lpmc_pkg::ADDR_STATUS: begin
				rd_mux[lpmc_pkg::STA_FSM_LO +: 3] = s_q.fsm;
				rd_mux[lpmc_pkg::STA_EVT] = s_q.evt_flag;
				rd_mux[lpmc_pkg::STA_SLEEPING] = asleep;
			end
			lpmc_pkg::ADDR_WAKE_FLAGS: begin
				rd_mux[lpmc_pkg::WK_UNIT] = s_q.wk_unit;
				rd_mux[lpmc_pkg::WK_RSTPIN] = s_q.wk_rst;
				rd_mux[lpmc_pkg::WK_ISO] = s_q.iso;
				rd_mux[lpmc_pkg::WK_IRQ] = s_q.irq_pend;
			end
			default: begin
				rd_mux = '0;
			end
		endcase
		if (psel && !penable && !pwrite) begin
			s_d.rdata = rd_mux;
		end

		// Register writes; status is read-only
		if (wr_en) begin
			case (paddr)
				lpmc_pkg::ADDR_SLEEP_CTRL: begin
					s_d.sah = pwdata[lpmc_pkg::SC_SAH];
					s_d.deep = pwdata[lpmc_pkg::SC_DEEP];
					s_d.eop = pwdata[lpmc_pkg::SC_EOP];
				end
				lpmc_pkg::ADDR_MODE_CTRL: begin
					s_d.run_lp = pwdata[lpmc_pkg::MC_RUN_LP];
					s_d.stop_kind = lpmc_pkg::lpmc_stop_t'(pwdata[lpmc_pkg::MC_STOP_LO +: 2]);
					s_d.lvl = pwdata[lpmc_pkg::MC_LVL_LO +: 2];
					s_d.por_opt = pwdata[lpmc_pkg::MC_POR];
					s_d.bus_on = pwdata[lpmc_pkg::MC_BUS_CLK];
				end
				lpmc_pkg::ADDR_WAKE_FLAGS: begin
					// Clearing a flag that is already clear has no effect
					if (pwdata[lpmc_pkg::WK_UNIT]) begin
						s_d.wk_unit = 1'b0;
					end
					if (pwdata[lpmc_pkg::WK_RSTPIN]) begin
						s_d.wk_rst = 1'b0;
					end
					if (pwdata[lpmc_pkg::WK_ISO] && s_q.iso) begin
						s_d.iso = 1'b0;
					end
					if (pwdata[lpmc_pkg::WK_IRQ]) begin
						s_d.irq_pend = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// Event flag: a set in the same cycle as the consuming wait wins
		if (wait_for_event_instr && s_q.evt_flag && !asleep) begin
			s_d.evt_flag = 1'b0;
		end
		if (send_event_instr || (event_in && !(asleep && s_q.wfe_wait))) begin
			s_d.evt_flag = 1'b1;
		end

		case (s_q.fsm)
			lpmc_pkg::FSM_RUN: begin
				if (sleep_go) begin
					// Deep sleep comes from the sleep control register set beforehand
					s_d.fsm = s_q.deep ? lpmc_pkg::FSM_STOP_ACK : lpmc_pkg::FSM_SLEEP;
					s_d.wfe_wait = wait_for_event_instr && !wait_for_irq_instr;
				end
			end
			lpmc_pkg::FSM_SLEEP: begin
				if (wake) begin
					s_d.fsm = lpmc_pkg::FSM_RUN;
					s_d.wfe_wait = 1'b0;
				end
			end
			lpmc_pkg::FSM_STOP_ACK: begin
				// Interrupts are not honoured once a leakage entry has begun
				if (wake && s_q.stop_kind != lpmc_pkg::STOP_LEAK) begin
					s_d.fsm = lpmc_pkg::FSM_RUN;
					s_d.wfe_wait = 1'b0;
				end else if (stop_ack_all) begin
					s_d.fsm = (s_q.stop_kind == lpmc_pkg::STOP_LEAK) ?
						lpmc_pkg::FSM_LEAK : lpmc_pkg::FSM_STOP;
				end
			end
			lpmc_pkg::FSM_STOP: begin
				if (wake) begin
					s_d.fsm = lpmc_pkg::FSM_RUN;
					s_d.wfe_wait = 1'b0;
				end
			end
			lpmc_pkg::FSM_LEAK: begin
				if (leak_wake) begin
					s_d.fsm = lpmc_pkg::FSM_RESTART;
					s_d.wfe_wait = 1'b0;
					s_d.iso = 1'b1;
					s_d.irq_pend = 1'b1;
					if (s_q.wku_s2) begin
						s_d.wk_unit = 1'b1;
					end
					if (!s_q.rpin_s2) begin
						s_d.wk_rst = 1'b1;
					end
				end
			end
			lpmc_pkg::FSM_RESTART: begin
				// Logic state was lost: control returns to reset values
				s_d.fsm = lpmc_pkg::FSM_RUN;
				s_d.sah = 1'b0;
				s_d.deep = 1'b0;
				s_d.eop = 1'b0;
				s_d.run_lp = 1'b0;
				s_d.stop_kind = lpmc_pkg::STOP_NORMAL;
				s_d.lvl = lpmc_pkg::LVL_RESET;
				s_d.por_opt = 1'b0;
				s_d.bus_on = 1'b0;
				s_d.evt_flag = 1'b0;
			end
			default: begin
				s_d.fsm = lpmc_pkg::FSM_RUN;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.fsm <= lpmc_pkg::FSM_RUN;
			s_q.stop_kind <= lpmc_pkg::STOP_NORMAL;
			s_q.lvl <= lpmc_pkg::LVL_RESET;
			s_q.rpin_s1 <= 1'b1;
			s_q.rpin_s2 <= 1'b1;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	// Output decode
	logic st_run;
	logic st_sleep;
	logic st_ack;
	logic st_stop;
	logic st_leak;
	logic st_rst;
	logic awake_clk;

	assign st_run = in_state(s_q.fsm, lpmc_pkg::FSM_RUN);
	assign st_sleep = in_state(s_q.fsm, lpmc_pkg::FSM_SLEEP);
	assign st_ack = in_state(s_q.fsm, lpmc_pkg::FSM_STOP_ACK);
	assign st_stop = in_state(s_q.fsm, lpmc_pkg::FSM_STOP);
	assign st_leak = in_state(s_q.fsm, lpmc_pkg::FSM_LEAK);
	assign st_rst = in_state(s_q.fsm, lpmc_pkg::FSM_RESTART);
	// Other masters keep their clocks until every stop acknowledge is in
	assign awake_clk = st_run || st_rst || st_sleep || st_ack;

	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_hit(paddr);
	assign prdata = s_q.rdata;
	assign event_out = s_q.ev_out;
	assign restart_req = st_rst;
	assign wake_unit_irq = s_q.irq_pend;
	assign core_sleeping = !(st_run || st_rst);

	assign clk_en.core = st_run || st_rst;
	assign clk_en.sys = awake_clk;
	assign clk_en.master = awake_clk;
	assign clk_en.bus = st_run || st_rst || ((st_sleep || st_ack) && s_q.bus_on);
	assign clk_en.flash = awake_clk;
	assign clk_en.pll = awake_clk;

	// Low-power regulator caps frequency wherever it is selected
	assign pwr.reg_lowpower = st_leak ||
		// Stop kind code 3 behaves as a normal stop and keeps the full regulator
		((st_stop || st_ack) && (s_q.stop_kind == lpmc_pkg::STOP_VLP || s_q.stop_kind == lpmc_pkg::STOP_LEAK)) ||
		((st_run || st_sleep) && s_q.run_lp);
	assign pwr.freq_limit = pwr.reg_lowpower;
	assign pwr.logic_on = !st_leak;
	assign pwr.ram_on = !(st_leak && s_q.lvl <= lpmc_pkg::LVL_ONE);
	// Pads stay held after wakeup until software releases them
	assign pwr.io_hold = st_leak || s_q.iso;
	assign pwr.osc_1k_on = !(st_leak && s_q.lvl == lpmc_pkg::LVL_ZERO);
	assign pwr.por_on = !(st_leak && s_q.lvl == lpmc_pkg::LVL_ZERO) || s_q.por_opt;
endmodule
`default_nettype wire

// file: verilog/lpmc_pkg.sv
// Constants and types for the low-power mode controller
// Function
// - Wait-for-interrupt instruction enters sleep immediately, no condition checked.
// - Wait-for-event sleeps if event flag is 0, else clears flag and continues.
// - Send-event signals all processors and sets the local event flag.
// - Deep-sleep select bit: 0 light sleep, 1 deep sleep.
// - Sleep-after-handler at 1 re-enters sleep on handler return to thread level.
// - Event-on-pending at 0: only enabled interrupts or events wake the processor.
// - Event-on-pending at 1: any newly pending interrupt is an event waking wait-for-event.
// - Event arriving while not waiting is recorded so next wait-for-event does not sleep.
// - Wait-for-event sleep also ends on system send-event or external event input.
// - Light sleep stops core clock; deep sleep also stops system clock, PLL, flash.
// - Full regulator in run, wait, stop; low-power regulator and frequency cap otherwise.
// - Wait mode gates core clock, keeps system clock, keeps enabled bus clocks.
// - Stop modes gate core first, other masters and buses after all stop acknowledges; here buses stop with the core if the bus clock bit is clear.
// - Very-low-power run caps clock frequencies and uses the low-power regulator.
// - Very-low-power wait gates core, keeps system, bus, flash clocks at capped rate; here the bus clock stops with the core if the bus clock bit is clear.
// - Low-leakage level three powers logic down, keeps RAM, holds I/O states.
// - Low-leakage level one also powers down system RAM.
// - Level zero disables 1 kHz oscillator; power-on reset kept only if option set.
// - Low-leakage levels wake only from wakeup unit or reset pin, not interrupts.
// - After leakage wakeup pads stay latched, flagged; writing 1 releases them.
// - Leakage wakeup returns to run with wakeup interrupt pending and source flags kept.
`default_nettype none
package lpmc_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_SLEEP_CTRL = 8'h00;
	localparam logic [7:0] ADDR_MODE_CTRL = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_WAKE_FLAGS = 8'h0C;
	// Sleep control fields
	localparam int SC_SAH = 1;
	localparam int SC_DEEP = 2;
	localparam int SC_EOP = 4;
	// Mode control fields
	localparam int MC_RUN_LP = 0;
	localparam int MC_STOP_LO = 1;
	localparam int MC_LVL_LO = 4;
	localparam int MC_POR = 8;
	localparam int MC_BUS_CLK = 12;
	// Status fields
	localparam int STA_FSM_LO = 0;
	localparam int STA_EVT = 4;
	localparam int STA_SLEEPING = 5;
	// Wake flag fields, write 1 to clear
	localparam int WK_UNIT = 0;
	localparam int WK_RSTPIN = 1;
	localparam int WK_ISO = 2;
	localparam int WK_IRQ = 3;
	// Low-leakage level codes
	localparam logic [1:0] LVL_ZERO = 2'h0;
	localparam logic [1:0] LVL_ONE = 2'h1;
	localparam logic [1:0] LVL_RESET = 2'h3;

	typedef enum logic [1:0] {
		STOP_NORMAL,
		STOP_VLP,
		STOP_LEAK
	} lpmc_stop_t;

	typedef enum logic [2:0] {
		FSM_RUN,
		FSM_SLEEP,
		FSM_STOP_ACK,
		FSM_STOP,
		FSM_LEAK,
		FSM_RESTART
	} lpmc_fsm_t;

	typedef struct packed {
		logic core;
		logic sys;
		logic bus;
		logic master;
		logic flash;
		logic pll;
	} lpmc_clk_t;

	typedef struct packed {
		logic reg_lowpower;
		logic freq_limit;
		logic logic_on;
		logic ram_on;
		logic io_hold;
		logic osc_1k_on;
		logic por_on;
	} lpmc_pwr_t;
endpackage
`default_nettype wire
